// [hw/pss_debounce.sv]
// Two-edge debouncer for pin inputs, counting 1 ms ticks.
`timescale 1ns/1ps
`default_nettype none
module pss_debounce #(
	parameter int unsigned N       = 5,
	parameter int unsigned CW      = 16,
	parameter logic [N-1:0] RST_VAL = '0
) (
	input wire logic clock,
	input wire logic rst,
	pss_db_if.core   db
);
	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] clean_q;
	logic [N-1:0] rise_q;
	logic [N-1:0] fall_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
		end else begin
			s1_q <= db.raw;
			s2_q <= s1_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			logic [CW-1:0] cnt_q;
			logic          differ;
			logic          done;
			assign differ = s2_q[i] != clean_q[i];
			assign done   = differ && db.tick && (cnt_q + 1'b1 >= db.limit[i]);
			// Any return to the old level restarts the full period.
			always_ff @(posedge clock) begin
				if (rst || !differ || done) begin
					cnt_q <= '0;
				end else if (db.tick) begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
			always_ff @(posedge clock) begin
				if (rst) begin
					clean_q[i] <= RST_VAL[i];
					rise_q[i]  <= 1'b0;
					fall_q[i]  <= 1'b0;
				end else begin
					clean_q[i] <= done ? s2_q[i] : clean_q[i];
					rise_q[i]  <= done && s2_q[i];
					fall_q[i]  <= done && !s2_q[i];
				end
			end
		end
	endgenerate

	assign db.clean = clean_q;
	assign db.rise  = rise_q;
	assign db.fall  = fall_q;
endmodule : pss_debounce
`default_nettype wire

// [hw/pss_power_state_ctrl.sv]
// On/off state controller with sequencer, watchdog and ship mode.
`timescale 1ns/1ps
`default_nettype none
module pss_power_state_ctrl
	import pss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = pss_pkg::TICK_CYCLES,
	parameter int unsigned MS_PER_S    = pss_pkg::MS_PER_S,
	parameter int unsigned EN_DB_MS    = pss_pkg::EN_DB_MS,
	parameter int unsigned SLOT_MS     = pss_pkg::SLOT_MS,
	parameter bit          WATCHDOG_LOCK_BIT    = 1'b0,
	parameter bit          WATCHDOG_ENABLE_BIT_DEF  = 1'b0
) (
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire logic                            enable_pin_low,
	input  wire logic                            charger_input_raw,
	input  wire logic [2:0]                      gpi_raw,
	input  wire logic                            die_overtemp,
	input  wire logic                            load_rail_uvlo,
	input  wire logic                            load_rail_ovlo,
	input  wire logic                            load_rail_low,
	input  wire logic                            cell_power_lost,
	input  wire logic                            soft_command_write,
	input  wire logic [1:0]                      soft_command_code,
	input  wire logic                            bias_request_bit,
	input  wire logic [3:0]                      analog_monitor_select,
	input  wire logic [pss_pkg::NUM_BUCK-1:0][2:0] buck_channel_enable_code,
	input  wire logic [2:0]                      linear_channel_enable_code,
	input  wire logic                            manual_reset_flag,
	input  wire logic                            watchdog_write,
	input  wire logic                            watchdog_enable_bit,
	input  wire logic [1:0]                      watchdog_period_select,
	input  wire logic                            watchdog_clear_bit,
	input  wire logic                            watchdog_action_select,
	input  wire logic                            expiry_flag_clear,
	output pss_pkg::pss_state_e                  ctrl_state,
	output logic                                 config_register_reset,
	output logic                                 host_access_ok,
	output logic                                 cell_disconnect,
	output logic                                 charger_feeds_load_rail,
	output logic                                 main_bias_on,
	output logic [pss_pkg::NUM_CH-1:0]           channel_on,
	output logic [2:0]                           sequencer_slot,
	output logic                                 wake_flag,
	output logic                                 watchdog_enable_state,
	output logic [1:0]                           watchdog_period_state,
	output logic                                 watchdog_lock_state,
	output logic                                 wdt_reset_flag,
	output logic                                 wdt_off_flag,
	output logic [1:0]                           charger_input_quality,
	output logic                                 enable_debounced,
	output logic [2:0]                           gpi_debounced
);
	function automatic logic is_on(input logic [2:0] code);
		is_on = code == EN_FORCE_ON;
	endfunction : is_on

	function automatic logic is_off(input logic [2:0] code);
		is_off = code == EN_FORCE_OFF;
	endfunction : is_off

	pss_state_e    state_q;
	pss_state_e    state_d;
	logic [31:0]   tick_cnt_q;
	logic          tick;
	logic [4:0]    sy1_q;
	logic [4:0]    sy2_q;
	logic [1:0]    cmd_q;
	logic          wake_q;
	logic          seq_done_q;
	logic [2:0]    slot_q;
	logic [15:0]   slot_cnt_q;
	logic          watchdog_enable_bit_q;
	logic [1:0]    watchdog_period_select_q;
	logic [31:0]   wdt_cnt_q;
	logic          wdt_exp_q;
	logic          wdt_rst_q;
	logic          wdt_off_q;
	logic [15:0]   exit_cnt_q;
	logic          feed_q;
	logic          cfg_rst_q;
	logic [NUM_CH-1:0] ch_q;
	logic          bias_q;

	pss_db_if #(.N(DB_N), .CW(DB_CW)) dbi ();

	pss_debounce #(
		.N       (DB_N),
		.CW      (DB_CW),
		.RST_VAL (DB_RST_VAL)
	) u_db (
		.clock (clock),
		.rst   (rst),
		.db    (dbi)
	);

	// Tick divider: every long timer runs on a 1 ms tick to keep counters narrow.
	assign tick = tick_cnt_q == TICK_CYCLES - 1;
	always_ff @(posedge clock) begin
		if (rst || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
	end

	// Analog comparator levels arrive from another domain.
	always_ff @(posedge clock) begin
		if (rst) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= {cell_power_lost, load_rail_low, load_rail_ovlo, load_rail_uvlo, die_overtemp};
			sy2_q <= sy1_q;
		end
	end

	assign dbi.tick              = tick;
	assign dbi.raw               = {gpi_raw, charger_input_raw, enable_pin_low};
	assign dbi.limit[DB_EN]      = DB_CW'(EN_DB_MS);
	assign dbi.limit[DB_CHG]     = DB_CW'(CHG_DB_MS);
	assign dbi.limit[DB_GPI]     = DB_CW'(GPI_DB_MS);
	assign dbi.limit[DB_GPI+1]   = DB_CW'(GPI_DB_MS);
	assign dbi.limit[DB_GPI+2]   = DB_CW'(GPI_DB_MS);

	wire en_db     = !dbi.clean[DB_EN];
	wire en_press  = dbi.fall[DB_EN];
	wire chg_ok    = dbi.clean[DB_CHG];
	wire chg_rise  = dbi.rise[DB_CHG];
	wire fault     = sy2_q[SY_OT] || sy2_q[SY_UV] || sy2_q[SY_OV];
	wire rail_low  = sy2_q[SY_LOW];
	wire pwr_lost  = sy2_q[SY_LOST];

	// Per-channel force decoding and sequencer participation.
	logic [NUM_CH-1:0] f_on;
	logic [NUM_CH-1:0] f_off;
	logic [NUM_CH-1:0] ch_d;
	wire seq_live = state_q == ST_RON || state_q == ST_PUP || state_q == ST_PDN;
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			wire [2:0] code = (c < NUM_BUCK) ? buck_channel_enable_code[c % NUM_BUCK]
			                                 : linear_channel_enable_code;
			assign f_on[c]  = is_on(code);
			assign f_off[c] = is_off(code);
			assign ch_d[c]  = (f_on[c] && !sy2_q[SY_UV])
			               || (!f_off[c] && !f_on[c] && seq_live && slot_q > 3'(c));
		end
	endgenerate

	wire any_on   = |f_on;
	wire all_off  = &f_off;
	wire res_on   = analog_monitor_select != 4'h0 || chg_ok || any_on || wake_q;
	wire stby_ok  = bias_request_bit || res_on;
	wire down_req = cmd_q != CMD_NONE || wdt_exp_q || manual_reset_flag;
	wire slot_end = tick && slot_cnt_q == 16'(SLOT_MS - 1);
	wire exit_ok  = rail_low && (chg_rise || exit_cnt_q >= 16'(SHIP_EXIT_MS));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (stby_ok) begin
					state_d = ST_STBY;
				end
			end
			ST_STBY: begin
				if (cmd_q == CMD_SHIP && !en_db) begin
					state_d = ST_SHIP;
				end else if (!stby_ok || down_req) begin
					state_d = ST_OFF;
				end else if (res_on && !fault) begin
					state_d = ST_RON;
				end
			end
			ST_RON: begin
				if (fault) begin
					state_d = ST_STBY;
				end else if (seq_done_q && (all_off || down_req)) begin
					state_d = ST_PDN;
				end else if (!res_on || down_req) begin
					state_d = ST_STBY;
				end else if (!seq_done_q && !all_off && wake_q) begin
					state_d = ST_PUP;
				end
			end
			ST_PUP: begin
				if (fault) begin
					state_d = ST_STBY;
				end else if (slot_q == SLOT_LAST) begin
					state_d = ST_RON;
				end
			end
			ST_PDN: begin
				if (slot_q == 3'h0) begin
					state_d = ST_STBY;
				end
			end
			ST_SHIP: begin
				if (pwr_lost || exit_ok) begin
					state_d = ST_OFF;
				end
			end
			default: state_d = ST_OFF;
		endcase
	end

	wire enter_ship = state_d == ST_SHIP && state_q != ST_SHIP;
	wire enter_off  = state_d == ST_OFF && state_q != ST_OFF;
	wire pup_done   = state_q == ST_PUP && state_d == ST_RON;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// The command is held until shutdown consumes it, so it cannot be lost mid-sequence.
	always_ff @(posedge clock) begin
		if (rst || cfg_rst_q || enter_off) begin
			cmd_q <= CMD_NONE;
		end else if (soft_command_write && state_q != ST_SHIP) begin
			cmd_q <= soft_command_code;
		end
	end

	wire wdt_run = watchdog_enable_bit_q && state_q != ST_OFF && state_q != ST_SHIP;
	wire [31:0] wdt_lim = (32'(WDT_MIN_S) * 32'(MS_PER_S)) << watchdog_period_select_q;
	wire wdt_hit = wdt_cnt_q + 32'h1 >= wdt_lim;
	wire wdt_fire = tick && wdt_run && wdt_hit;

	// Setting wins over the completion clear.
	wire wake_set = en_press || chg_rise || (soft_command_write && soft_command_code == CMD_COLD)
	             || (tick && wdt_run && wdt_hit && watchdog_action_select);
	always_ff @(posedge clock) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else if (wake_set) begin
			wake_q <= 1'b1;
		end else if (pup_done) begin
			wake_q <= 1'b0;
		end
	end

	// Master sequencing timer.
	always_ff @(posedge clock) begin
		if (rst || !(state_q == ST_PUP || state_q == ST_PDN) || slot_end) begin
			slot_cnt_q <= '0;
		end else if (tick) begin
			slot_cnt_q <= slot_cnt_q + 16'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || state_q == ST_OFF || state_q == ST_STBY) begin
			slot_q     <= 3'h0;
			seq_done_q <= 1'b0;
		end else begin
			if (state_q == ST_PUP && slot_end && slot_q != SLOT_LAST) begin
				slot_q <= slot_q + 3'h1;
			end else if (state_q == ST_PDN && slot_end && slot_q != 3'h0) begin
				slot_q <= slot_q - 3'h1;
			end
			if (pup_done) begin
				seq_done_q <= 1'b1;
			end
		end
	end

	// Watchdog configuration under the factory lock options.
	always_ff @(posedge clock) begin
		if (rst || cfg_rst_q) begin
			watchdog_enable_bit_q  <= WATCHDOG_ENABLE_BIT_DEF;
			watchdog_period_select_q <= WATCHDOG_PERIOD_SELECT_RST;
		end else if (watchdog_write && state_q != ST_SHIP) begin
			watchdog_period_select_q <= watchdog_period_select;
			if (!WATCHDOG_LOCK_BIT) begin
				watchdog_enable_bit_q <= watchdog_enable_bit;
			end else if (!WATCHDOG_ENABLE_BIT_DEF) begin
				watchdog_enable_bit_q <= watchdog_enable_bit_q || watchdog_enable_bit;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !wdt_run || wdt_fire || (watchdog_clear_bit && watchdog_write)) begin
			wdt_cnt_q <= '0;
		end else if (tick) begin
			wdt_cnt_q <= wdt_cnt_q + 32'h1;
		end
	end

	// Expiry forces the path to shutdown; the recorded cause survives it.
	always_ff @(posedge clock) begin
		if (rst) begin
			wdt_exp_q <= 1'b0;
			wdt_rst_q <= 1'b0;
			wdt_off_q <= 1'b0;
		end else begin
			wdt_exp_q <= wdt_fire || (wdt_exp_q && !enter_off);
			wdt_rst_q <= (wdt_fire && watchdog_action_select)
			          || (wdt_rst_q && !expiry_flag_clear);
			wdt_off_q <= (wdt_fire && !watchdog_action_select)
			          || (wdt_off_q && !expiry_flag_clear);
		end
	end

	// Ship exit interval only starts once the pin debounce has settled.
	always_ff @(posedge clock) begin
		if (rst || state_q != ST_SHIP || !en_db) begin
			exit_cnt_q <= '0;
		end else if (tick && exit_cnt_q < 16'(SHIP_EXIT_MS)) begin
			exit_cnt_q <= exit_cnt_q + 16'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			feed_q    <= 1'b0;
			cfg_rst_q <= 1'b0;
			ch_q      <= '0;
			bias_q    <= 1'b0;
		end else begin
			feed_q    <= enter_ship ? chg_ok
			           : (feed_q && chg_ok && state_q == ST_SHIP);
			cfg_rst_q <= enter_ship || wdt_fire;
			ch_q      <= ch_d;
			bias_q    <= any_on || (state_d != ST_OFF && state_d != ST_SHIP);
		end
	end

	assign ctrl_state              = state_q;
	assign config_register_reset   = cfg_rst_q;
	assign host_access_ok          = state_q != ST_SHIP;
	assign cell_disconnect         = state_q == ST_SHIP;
	assign charger_feeds_load_rail = feed_q;
	assign main_bias_on            = bias_q;
	assign channel_on              = ch_q;
	assign sequencer_slot          = slot_q;
	assign wake_flag               = wake_q;
	assign watchdog_enable_state   = watchdog_enable_bit_q;
	assign watchdog_period_state   = watchdog_period_select_q;
	assign watchdog_lock_state     = WATCHDOG_LOCK_BIT;
	assign wdt_reset_flag          = wdt_rst_q;
	assign wdt_off_flag            = wdt_off_q;
	assign charger_input_quality   = chg_ok ? CHG_Q_VALID : CHG_Q_INVALID;
	assign enable_debounced        = en_db;
	assign gpi_debounced           = dbi.clean[DB_GPI+2:DB_GPI];
endmodule : pss_power_state_ctrl
`default_nettype wire

// [inc/pss_db_if.sv]
// Carrier between the controller and its input debouncer.
`timescale 1ns/1ps
`default_nettype none
interface pss_db_if #(
	parameter int unsigned N  = 5,
	parameter int unsigned CW = 16
);
	logic                 tick;
	logic [N-1:0]         raw;
	logic [N-1:0][CW-1:0] limit;
	logic [N-1:0]         clean;
	logic [N-1:0]         rise;
	logic [N-1:0]         fall;
	modport core (input tick, input raw, input limit, output clean, output rise, output fall);
	modport user (output tick, output raw, output limit, input clean, input rise, input fall);
endinterface : pss_db_if
`default_nettype wire

// [inc/pss_pkg.sv]
// Shared constants and types for the power state controller.
`default_nettype none
package pss_pkg;
	// Clock and base tick; all long timers count 1 ms ticks.
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS       = 1000000;
	localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned MS_PER_S      = 1000;
	// Debounce, exit and sequencer slot times in ms.
	localparam int unsigned CHG_DB_MS     = 120;
	localparam int unsigned GPI_DB_MS     = 30;
	localparam int unsigned EN_DB_MS      = 30;
	localparam int unsigned SHIP_EXIT_MS  = 250;
	localparam int unsigned SLOT_MS       = 2;
	// Watchdog period: shortest value shifted left by the select field.
	localparam int unsigned WDT_MIN_S     = 16;
	localparam logic [1:0]  WATCHDOG_PERIOD_SELECT_RST   = 2'h3;
	// Soft command codes.
	localparam logic [1:0]  CMD_NONE      = 2'h0;
	localparam logic [1:0]  CMD_COLD      = 2'h1;
	localparam logic [1:0]  CMD_OFF       = 2'h2;
	localparam logic [1:0]  CMD_SHIP      = 2'h3;
	// Channel enable codes and charger quality values.
	localparam logic [2:0]  EN_FORCE_ON   = 3'h6;
	localparam logic [2:0]  EN_FORCE_OFF  = 3'h4;
	localparam logic [1:0]  CHG_Q_VALID   = 2'h3;
	localparam logic [1:0]  CHG_Q_INVALID = 2'h0;
	// Channel counts and sequencer slots.
	localparam int unsigned NUM_BUCK      = 3;
	localparam int unsigned NUM_CH        = 4;
	localparam logic [2:0]  SLOT_LAST     = 3'h4;
	// Debounced input indices.
	localparam int unsigned DB_N          = 5;
	localparam int unsigned DB_EN         = 0;
	localparam int unsigned DB_CHG        = 1;
	localparam int unsigned DB_GPI        = 2;
	localparam int unsigned DB_CW         = 16;
	localparam logic [4:0]  DB_RST_VAL    = 5'h01;
	// Synchronised level indices.
	localparam int unsigned SY_OT         = 0;
	localparam int unsigned SY_UV         = 1;
	localparam int unsigned SY_OV         = 2;
	localparam int unsigned SY_LOW        = 3;
	localparam int unsigned SY_LOST       = 4;

	typedef enum logic [5:0] {
		ST_OFF  = 6'h01,
		ST_STBY = 6'h02,
		ST_RON  = 6'h04,
		ST_PUP  = 6'h08,
		ST_PDN  = 6'h10,
		ST_SHIP = 6'h20
	} pss_state_e;
endpackage : pss_pkg
`default_nettype wire

// [sim/pss_far_button.sv]
// Push-button model on the enable pin, with contact chatter after each change.
`timescale 1ns/1ps
`default_nettype none
module pss_far_button (
	input  wire logic clock,
	input  wire logic press,
	output var logic  enable_pin_low
);
	logic       last_q;
	logic [2:0] chatter_q;
	initial begin
		last_q = 1'b0;
		chatter_q = 3'h0;
		enable_pin_low = 1'b1;
	end
	// The pull-up holds the pin high when released; chatter toggles it every cycle.
	always @(posedge clock) begin
		if (press != last_q) chatter_q <= 3'h5;
		else if (chatter_q != 3'h0) chatter_q <= chatter_q - 3'h1;
		last_q <= press;
		enable_pin_low <= (chatter_q != 3'h0) ? ~enable_pin_low : ~press;
	end
endmodule : pss_far_button
`default_nettype wire

// [sim/pss_power_state_ctrl_asserts.sv]
// Port-level assertions for the power state controller.
`timescale 1ns/1ps
`default_nettype none
module pss_power_state_ctrl_asserts
	import pss_pkg::*;
(
	input wire logic                clock,
	input wire logic                rst,
	input wire logic                die_overtemp,
	input wire logic                load_rail_uvlo,
	input wire logic                load_rail_ovlo,
	input wire logic                load_rail_low,
	input wire logic                cell_power_lost,
	input wire logic                soft_command_write,
	input wire logic [1:0]          soft_command_code,
	input wire logic [2:0]          linear_channel_enable_code,
	input wire logic                watchdog_write,
	input wire logic                watchdog_enable_bit,
	input wire pss_pkg::pss_state_e ctrl_state,
	input wire logic                config_register_reset,
	input wire logic                host_access_ok,
	input wire logic                cell_disconnect,
	input wire logic                main_bias_on,
	input wire logic [3:0]          channel_on,
	input wire logic                wake_flag,
	input wire logic                watchdog_enable_state,
	input wire logic                watchdog_lock_state,
	input wire logic                wdt_reset_flag,
	input wire logic                wdt_off_flag,
	input wire logic                enable_debounced
);
	import pss_pkg::*;
	logic lock_any;
	assign lock_any = die_overtemp | load_rail_uvlo | load_rail_ovlo;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_ship_host_block: assert property (host_access_ok == (ctrl_state != ST_SHIP)
		&& cell_disconnect == (ctrl_state == ST_SHIP)) else $error("ship decode wrong");
	chk_ship_from_stby: assert property (ctrl_state == ST_SHIP && $past(ctrl_state) != ST_SHIP
		|-> $past(ctrl_state) == ST_STBY && !$past(enable_debounced)) else $error("bad ship entry");
	chk_ship_exit_cause: assert property ($past(ctrl_state) == ST_SHIP && ctrl_state != ST_SHIP
		|-> $past(load_rail_low, 3) || $past(cell_power_lost, 3)) else $error("early ship exit");
	chk_lockout_leaves: assert property (lock_any [*6]
		|-> !(ctrl_state inside {ST_RON, ST_PUP})) else $error("powered during lockout");
	chk_force_on_run: assert property ((linear_channel_enable_code == EN_FORCE_ON && !lock_any
		&& ctrl_state != ST_SHIP) [*8] |-> channel_on[3] && main_bias_on) else $error("force-on idle");
	chk_pup_wake: assert property (ctrl_state == ST_PUP && $past(ctrl_state) != ST_PUP
		|-> $past(ctrl_state) == ST_RON && $past(wake_flag)) else $error("power-up without wake");
	chk_off_cmd_walk: assert property (ctrl_state == ST_RON && soft_command_write
		&& soft_command_code == CMD_OFF |-> ##2 ctrl_state inside {ST_STBY, ST_PDN})
		else $error("off command ignored");
	chk_wdt_flag_cfg: assert property ($rose(wdt_off_flag) || $rose(wdt_reset_flag)
		|-> config_register_reset) else $error("expiry without config reset");
	chk_lock_keeps_en: assert property (watchdog_lock_state && watchdog_write
		&& !watchdog_enable_bit && watchdog_enable_state && host_access_ok
		|=> watchdog_enable_state || config_register_reset) else $error("locked enable cleared");
endmodule : pss_power_state_ctrl_asserts
bind pss_power_state_ctrl pss_power_state_ctrl_asserts pss_power_state_ctrl_asserts_i (
	.clock, .rst, .die_overtemp, .load_rail_uvlo, .load_rail_ovlo, .load_rail_low,
	.cell_power_lost, .soft_command_write, .soft_command_code, .linear_channel_enable_code,
	.watchdog_write, .watchdog_enable_bit, .ctrl_state, .config_register_reset, .host_access_ok,
	.cell_disconnect, .main_bias_on, .channel_on, .wake_flag, .watchdog_enable_state,
	.watchdog_lock_state, .wdt_reset_flag, .wdt_off_flag, .enable_debounced
);
`default_nettype wire

// [sim/test_power_state_controller.sv]
// Self-checking bench for the power state controller with a push-button model.
`timescale 1ns/1ps
`default_nettype none
module test_power_state_controller;
	import pss_pkg::*;
	logic clock, rst, press, charger_input_raw, die_overtemp, load_rail_uvlo, load_rail_ovlo;
	logic load_rail_low, cell_power_lost, soft_command_write, bias_request_bit, manual_reset_flag;
	logic watchdog_write, watchdog_enable_bit, watchdog_clear_bit, watchdog_action_select;
	logic expiry_flag_clear, config_register_reset, host_access_ok, cell_disconnect, wake_flag;
	logic charger_feeds_load_rail, main_bias_on, watchdog_enable_state, watchdog_lock_state;
	logic wdt_reset_flag, wdt_off_flag, enable_debounced;
	logic [1:0] soft_command_code, watchdog_period_select, watchdog_period_state;
	logic [1:0] charger_input_quality;
	logic [2:0] gpi_raw, gpi_debounced, linear_channel_enable_code, sequencer_slot;
	logic [3:0] analog_monitor_select, channel_on;
	logic [2:0][2:0] buck_channel_enable_code;
	logic [7:0] lfsr;
	wire logic enable_pin_low;
	pss_state_e ctrl_state;
	int n_mismatch = 0;
	int check_count = 0;
	pss_far_button pss_far_button_i (.clock, .press, .enable_pin_low);
	// Short tick and watchdog scaling keep the 250 ms ship-exit hold near 1000 cycles.
	pss_power_state_ctrl #(.TICK_CYCLES(4), .MS_PER_S(2), .EN_DB_MS(2),
		.WATCHDOG_LOCK_BIT(1'b1)) pss_power_state_ctrl_i (.clock, .rst,
		.enable_pin_low, .charger_input_raw, .gpi_raw, .die_overtemp, .load_rail_uvlo,
		.load_rail_ovlo, .load_rail_low, .cell_power_lost, .soft_command_write,
		.soft_command_code, .bias_request_bit, .analog_monitor_select, .buck_channel_enable_code,
		.linear_channel_enable_code, .manual_reset_flag, .watchdog_write, .watchdog_enable_bit,
		.watchdog_period_select, .watchdog_clear_bit, .watchdog_action_select, .expiry_flag_clear,
		.ctrl_state, .config_register_reset, .host_access_ok, .cell_disconnect,
		.charger_feeds_load_rail, .main_bias_on, .channel_on, .sequencer_slot, .wake_flag,
		.watchdog_enable_state, .watchdog_period_state, .watchdog_lock_state, .wdt_reset_flag,
		.wdt_off_flag, .charger_input_quality, .enable_debounced, .gpi_debounced);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits until the state equals s (want=1) or differs from it (want=0).
	task automatic wait_for(input pss_state_e s, input logic want, input int bound);
		int i;
		for (i = 0; i < bound && (ctrl_state === s) !== want; i++) @(negedge clock);
		check(ctrl_state === s, want);
		if ((ctrl_state === s) !== want) finish_test();
	endtask : wait_for
	task automatic ticks(input int n);
		repeat (n * 4) @(negedge clock);
	endtask : ticks
	task automatic cmd(input logic [1:0] code);
		@(negedge clock);
		soft_command_write = 1'b1;
		soft_command_code = code;
		@(negedge clock);
		soft_command_write = 1'b0;
	endtask : cmd
	task automatic wdog(input logic en, input logic [1:0] sel, input logic clr);
		@(negedge clock);
		{watchdog_write, watchdog_enable_bit, watchdog_period_select, watchdog_clear_bit} =
			{1'b1, en, sel, clr};
		@(negedge clock);
		watchdog_write = 1'b0;
	endtask : wdog
	// Queue model of the sequencer: each change of channel_on must pop the next mask.
	task automatic seq_watch(input pss_state_e s, input logic [3:0] last, input logic [3:0] q[$]);
		int i;
		for (i = 0; i < 400 && ctrl_state === s; i++) begin
			@(negedge clock);
			if (channel_on !== last) begin
				last = channel_on;
				check(channel_on, (q.size() != 0) ? q.pop_front() : 4'hf);
			end
		end
		check(q.size(), 0);
	endtask : seq_watch
	initial begin
		{rst, press, charger_input_raw, die_overtemp, load_rail_uvlo, load_rail_ovlo} = 6'h20;
		{load_rail_low, cell_power_lost, soft_command_write, bias_request_bit} = 4'h0;
		{manual_reset_flag, watchdog_write, watchdog_enable_bit, watchdog_clear_bit} = 4'h0;
		{watchdog_action_select, expiry_flag_clear, soft_command_code} = 4'h0;
		{watchdog_period_select, gpi_raw, analog_monitor_select} = 9'h000;
		buck_channel_enable_code = 9'h000;
		linear_channel_enable_code = EN_FORCE_OFF;
		lfsr = 8'h38;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		check(ctrl_state, ST_OFF);
		check(watchdog_period_state, 2'h3);
		check({watchdog_lock_state, watchdog_enable_state, host_access_ok}, 3'h5);
		lfsr = lfsr_next(lfsr);
		gpi_raw = lfsr[2:0] | 3'h1;
		ticks(20);
		check(gpi_debounced, 3'h0);
		ticks(14);
		check(gpi_debounced, lfsr[2:0] | 3'h1);
		bias_request_bit = 1'b1;
		wait_for(ST_STBY, 1'b1, 10);
		manual_reset_flag = 1'b1;
		wait_for(ST_OFF, 1'b1, 10);
		manual_reset_flag = 1'b0;
		bias_request_bit = 1'b0;
		lfsr = lfsr_next(lfsr);
		analog_monitor_select = lfsr[3:0] | 4'h8;
		wait_for(ST_RON, 1'b1, 10);
		press = 1'b1;
		wait_for(ST_PUP, 1'b1, 200);
		seq_watch(ST_PUP, 4'h0, '{4'h1, 4'h3, 4'h7});
		check({ctrl_state === ST_RON, channel_on[3], wake_flag}, 3'h4);
		check(sequencer_slot, SLOT_LAST);
		press = 1'b0;
		ticks(10);
		cmd(CMD_OFF);
		analog_monitor_select = 4'h0;
		wait_for(ST_PDN, 1'b1, 4);
		seq_watch(ST_PDN, 4'h7, '{4'h3, 4'h1, 4'h0});
		wait_for(ST_OFF, 1'b1, 50);
		linear_channel_enable_code = EN_FORCE_ON;
		for (int k = 0; k < 3; k++) begin
			buck_channel_enable_code[k] = EN_FORCE_ON;
			wait_for(ST_RON, 1'b1, 30);
			check({channel_on[3], channel_on[k], main_bias_on}, 3'h7);
			{die_overtemp, load_rail_uvlo, load_rail_ovlo} = 3'h4 >> k;
			ticks(3);
			check(ctrl_state inside {ST_RON, ST_PUP}, 1'b0);
			{die_overtemp, load_rail_uvlo, load_rail_ovlo} = 3'h0;
		end
		{buck_channel_enable_code, linear_channel_enable_code} = 12'h000;
		charger_input_raw = 1'b1;
		ticks(110);
		check(charger_input_quality, CHG_Q_INVALID);
		ticks(16);
		check(charger_input_quality, CHG_Q_VALID);
		cmd(CMD_SHIP);
		wait_for(ST_SHIP, 1'b1, 600);
		check({cell_disconnect, host_access_ok, charger_feeds_load_rail}, 3'h5);
		charger_input_raw = 1'b0;
		ticks(126);
		check(charger_feeds_load_rail, 1'b0);
		charger_input_raw = 1'b1;
		ticks(126);
		check(ctrl_state, ST_SHIP);
		charger_input_raw = 1'b0;
		load_rail_low = 1'b1;
		ticks(126);
		charger_input_raw = 1'b1;
		wait_for(ST_SHIP, 1'b0, 600);
		cmd(CMD_SHIP);
		wait_for(ST_SHIP, 1'b1, 600);
		press = 1'b1;
		ticks(200);
		check(ctrl_state, ST_SHIP);
		wait_for(ST_SHIP, 1'b0, 400);
		{press, charger_input_raw, load_rail_low} = 3'h0;
		ticks(130);
		cmd(CMD_OFF);
		wait_for(ST_OFF, 1'b1, 400);
		bias_request_bit = 1'b1;
		wait_for(ST_STBY, 1'b1, 10);
		cmd(CMD_SHIP);
		wait_for(ST_SHIP, 1'b1, 10);
		cell_power_lost = 1'b1;
		wait_for(ST_SHIP, 1'b0, 8);
		cell_power_lost = 1'b0;
		for (int m = 0; m < 2; m++) begin
			watchdog_action_select = m[0];
			wdog(1'b1, 2'h0, 1'b1);
			check({watchdog_enable_state, watchdog_period_state}, 3'h4);
			wdog(1'b0, 2'h1, 1'b0);
			check({watchdog_enable_state, watchdog_period_state}, 3'h5);
			ticks(24);
			wdog(1'b1, 2'h0, 1'b1);
			ticks(24);
			check({wdt_reset_flag, wdt_off_flag}, 2'h0);
			ticks(12);
			check({wdt_reset_flag, wdt_off_flag}, m[0] ? 2'h2 : 2'h1);
			check({watchdog_enable_state, watchdog_period_state}, 3'h3);
			@(negedge clock) expiry_flag_clear = 1'b1;
			@(negedge clock) expiry_flag_clear = 1'b0;
			check({wdt_reset_flag, wdt_off_flag}, 2'h0);
		end
		finish_test();
	end
endmodule : test_power_state_controller
`default_nettype wire
